// ---- tmz_timer.v ----
// timer zero with shared scaler, watchdog and apb register slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "tmz_defs.vh"

// How it works
// - external clock path is sampled on the second and fourth phase clocks
// - with scaler on timer, external clock is divided ahead of sampling
// - external clock steps the timer only after the sampled scaler output, or the source without scaler, is seen rising
// - one 8-bit scaler serves either timer or watchdog, never both
// - option low nibble holds assignment bit and three-bit ratio
// - any timer count write clears the scaler while assigned to timer
// - watchdog clear op clears scaler and watchdog while assigned to watchdog
// - scaler is hidden from software and zero after reset
// - timer source select forces the external clock pin to input
// - watchdog division reaches 1:128 when scaler is on watchdog
// - sleep op resets watchdog and scaler when scaler is on watchdog
module tmz_timer #(
	parameter WDT_BASE_CYCLES = `TMZ_WDT_BASE_US * `TMZ_CLK_MHZ,
	parameter WDT_CNT_W = 22
) (
	input wire sys_clk,
	input wire reset,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire timer_ext_clock_pin,
	input wire comparator_out,
	input wire watchdog_enable,
	output wire [5:0] port_direction_eff,
	output wire watchdog_timeout
);
	// full-width products, cut to register width on purpose
	localparam [31:0] HOLD_FULL = `TMZ_HOLD_INSTR * `TMZ_PHASES;
	localparam [31:0] WDT_LAST_FULL = WDT_BASE_CYCLES - 1;
	localparam [7:0] HOLD_CLKS = HOLD_FULL[7:0];
	localparam [WDT_CNT_W-1:0] WDT_LAST = WDT_LAST_FULL[WDT_CNT_W-1:0];

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// scaler bit that gives the timer ratio 1:2 at 000 up to 1:256
	function sel_bit;
		input [7:0] sc;
		input [2:0] r;
		begin
			sel_bit = sc[r];
		end
	endfunction

	// low bits that must all be set for watchdog ratio 1:1 up to 1:128
	function [7:0] wd_mask;
		input [2:0] r;
		begin
			wd_mask = (8'h01 << r) - 8'h01;
		end
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	reg [7:0] option_q;
	reg [7:0] cmp_ctrl_q;
	reg [5:0] port_dir_q;
	reg [7:0] count_q;
	reg [7:0] scaler_q;
	reg [1:0] phase_q;
	reg [7:0] hold_q;
	reg [WDT_CNT_W-1:0] wd_cnt_q;
	reg wd_timeout_q;
	reg src_prev_q;
	reg samp_q;
	reg pready_q;
	reg pslverr_q;
	reg [31:0] prdata_q;

	// ----------------------------------------------------------------
	// outside inputs: three flops, change taken when last two agree
	// ----------------------------------------------------------------
	wire [1:0] raw_in = {comparator_out, timer_ext_clock_pin};
	wire [1:0] lvl_now;
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
			reg [2:0] s_q;
			reg l_q;
			always @(posedge sys_clk) begin
				if (reset) begin
					s_q <= 3'h0;
					l_q <= 1'b0;
				end else if (clk_en) begin
					s_q <= {s_q[1:0], raw_in[gi]};
					if (s_q[1] == s_q[2])
						l_q <= s_q[2];
				end
			end
			assign lvl_now[gi] = l_q;
		end
	endgenerate

	// ----------------------------------------------------------------
	// source and scaler selection
	// ----------------------------------------------------------------
	wire cmp_on = cmp_ctrl_q[`TMZ_CMP_ENABLE];
	// comparator clock select honoured only while comparator runs
	wire use_cmp = cmp_on & ~cmp_ctrl_q[`TMZ_CMP_CLKSEL];
	wire ext_src = use_cmp | option_q[`TMZ_OPT_SRC];
	wire [2:0] ratio = option_q[`TMZ_OPT_RATIO_HI:`TMZ_OPT_RATIO_LO];
	wire sc_to_timer = ~option_q[`TMZ_OPT_ASSIGN];
	wire ext_raw = use_cmp ? lvl_now[1] : lvl_now[0];
	wire src_lvl = ext_raw ^ option_q[`TMZ_OPT_EDGE];
	wire src_rise = src_lvl & ~src_prev_q;
	wire is_q4 = (phase_q == `TMZ_PH_FOURTH);
	wire is_q2 = (phase_q == `TMZ_PH_SECOND);
	wire [7:0] scaler_inc = scaler_q + 8'h01;

	// divided output, or the source itself when no scaler on timer
	wire pres_out = sc_to_timer ? sel_bit(scaler_q, ratio) : src_lvl;
	// internal clock: every instruction, or on rise of the chosen bit
	wire int_tick = is_q4 & (~sc_to_timer |
		(sel_bit(scaler_inc, ratio) & ~sel_bit(scaler_q, ratio)));
	// external clock: rise seen only at a phase sample point
	wire ext_tick = (is_q2 | is_q4) & pres_out & ~samp_q;
	wire timer_tick = ext_src ? ext_tick : int_tick;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	wire [7:0] idx = {2'h0, paddr[7:2]};
	wire acc = psel & penable;
	wire wr_done = acc & pwrite & pready_q;
	wire mapped = (paddr[1:0] == 2'h0) && (idx == `TMZ_IDX_COUNT ||
		idx == `TMZ_IDX_CMP_A || idx == `TMZ_IDX_CMP_B ||
		idx == `TMZ_IDX_OPTION || idx == `TMZ_IDX_PORTDIR ||
		idx == `TMZ_IDX_OPS || idx == `TMZ_IDX_STATE);
	wire wr_ok = wr_done & mapped;
	wire wr_count = wr_ok & (idx == `TMZ_IDX_COUNT);
	wire wr_cmp = wr_ok & (idx == `TMZ_IDX_CMP_A || idx == `TMZ_IDX_CMP_B);
	wire wr_ops = wr_ok & (idx == `TMZ_IDX_OPS);
	wire wd_clear = wr_ops & pwdata[`TMZ_OPS_WDCLR];
	wire sleep_op = wr_ops & pwdata[`TMZ_OPS_SLEEP];
	// clearing ops reset the watchdog, and the scaler when it is the watchdog's
	wire wd_restart = wd_clear | sleep_op;

	// watchdog base period elapsed
	wire wd_base = watchdog_enable & (wd_cnt_q == WDT_LAST);
	wire wd_fire = wd_base & ~sc_to_timer &
		((scaler_q & wd_mask(ratio)) == wd_mask(ratio));

	// read mux: write-only registers read as zero, scaler never visible
	reg [31:0] rd_val;
	always @* begin
		rd_val = 32'h0000_0000;
		case (idx)
			`TMZ_IDX_COUNT: rd_val = {24'h000000, count_q};
			`TMZ_IDX_CMP_A,
			`TMZ_IDX_CMP_B: rd_val = {24'h000000, lvl_now[1], cmp_ctrl_q[6:0]};
			`TMZ_IDX_STATE: rd_val = {28'h0000000, hold_q != 8'h00, ext_src,
				sc_to_timer, phase_q == `TMZ_PH_FOURTH};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// apb slave: one wait state, answer registered
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (clk_en) begin
			if (acc & ~pready_q) begin
				pready_q <= 1'b1;
				pslverr_q <= ~mapped;
				prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
			end else begin
				pready_q <= 1'b0;
				pslverr_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			option_q <= `TMZ_RST_OPTION;
			cmp_ctrl_q <= `TMZ_RST_CMP;
			port_dir_q <= `TMZ_RST_PORTDIR;
		end else if (clk_en) begin
			if (wr_ok & (idx == `TMZ_IDX_OPTION))
				option_q <= pwdata[7:0];
			if (wr_cmp)
				cmp_ctrl_q <= {1'b1, pwdata[6:0]};
			if (wr_ok & (idx == `TMZ_IDX_PORTDIR))
				port_dir_q <= pwdata[5:0];
		end
	end

	// ----------------------------------------------------------------
	// phase clocks and source edge tracking
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			phase_q <= 2'h0;
			src_prev_q <= 1'b1; // reset option picks falling edge: idle pin reads high
			samp_q <= 1'b1; // no false count right after reset
		end else if (clk_en) begin
			phase_q <= phase_q + 2'h1;
			src_prev_q <= src_lvl;
			if (is_q2 | is_q4)
				samp_q <= pres_out;
		end
	end

	// ----------------------------------------------------------------
	// shared scaler
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			scaler_q <= `TMZ_RST_SCALER;
		end else if (clk_en) begin
			if (sc_to_timer) begin
				if (wr_count)
					scaler_q <= `TMZ_RST_SCALER;
				else if (ext_src ? src_rise : is_q4)
					scaler_q <= scaler_inc;
			end else begin
				if (wd_restart | wd_fire)
					scaler_q <= `TMZ_RST_SCALER;
				else if (wd_base)
					scaler_q <= scaler_inc;
			end
		end
	end

	// ----------------------------------------------------------------
	// timer count with hold after write
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			count_q <= `TMZ_RST_COUNT;
			hold_q <= 8'h00;
		end else if (clk_en) begin
			if (wr_count) begin
				count_q <= pwdata[7:0];
				hold_q <= HOLD_CLKS;
			end else if (hold_q != 8'h00) begin
				hold_q <= hold_q - 8'h01;
			end else if (timer_tick) begin
				count_q <= count_q + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// watchdog base counter and timeout pulse
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (reset) begin
			wd_cnt_q <= {WDT_CNT_W{1'b0}};
			wd_timeout_q <= 1'b0;
		end else if (clk_en) begin
			wd_timeout_q <= 1'b0;
			if (wd_restart | ~watchdog_enable) begin
				wd_cnt_q <= {WDT_CNT_W{1'b0}};
			end else if (wd_base) begin
				wd_cnt_q <= {WDT_CNT_W{1'b0}};
				// no scaler on watchdog means 1:1
				wd_timeout_q <= sc_to_timer | wd_fire;
			end else begin
				wd_cnt_q <= wd_cnt_q + {{(WDT_CNT_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// pin direction forced to input when the pin clocks the timer
	assign port_direction_eff = {port_dir_q[`TMZ_EXT_PIN_BIT] |
		option_q[`TMZ_OPT_SRC], port_dir_q[4:0]};
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign watchdog_timeout = wd_timeout_q;
endmodule // tmz_timer

// ---- tmz_defs.vh ----
// constants for the timer zero block with its shared scaler
`ifndef TMZ_DEFS_VH
`define TMZ_DEFS_VH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define TMZ_IDX_COUNT 8'h01
`define TMZ_IDX_CMP_A 8'h07
`define TMZ_IDX_CMP_B 8'h08
`define TMZ_IDX_OPTION 8'h10
`define TMZ_IDX_PORTDIR 8'h11
`define TMZ_IDX_OPS 8'h12
`define TMZ_IDX_STATE 8'h13
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TMZ_RST_OPTION 8'hFF
`define TMZ_RST_CMP 8'hFF
`define TMZ_RST_PORTDIR 6'h3F
`define TMZ_RST_COUNT 8'h00
`define TMZ_RST_SCALER 8'h00
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define TMZ_OPT_SRC 5
`define TMZ_OPT_EDGE 4
`define TMZ_OPT_ASSIGN 3
`define TMZ_OPT_RATIO_HI 2
`define TMZ_OPT_RATIO_LO 0
`define TMZ_CMP_OUT 7
`define TMZ_CMP_CLKSEL 4
`define TMZ_CMP_ENABLE 3
`define TMZ_OPS_WDCLR 0
`define TMZ_OPS_SLEEP 1
`define TMZ_EXT_PIN_BIT 5
// ----------------------------------------------------------------
// phases and timing
// ----------------------------------------------------------------
`define TMZ_PH_SECOND 2'h1
`define TMZ_PH_FOURTH 2'h3
`define TMZ_PHASES 4
`define TMZ_HOLD_INSTR 2
`define TMZ_CLK_MHZ 200
`define TMZ_WDT_BASE_US 18000
`endif

// ---- tmz_chk.sv ----
// assertion checker for the timer zero block
`timescale 1ns/1ps
module tmz_chk #(
	parameter WDT_BASE_CYCLES = 16,
	parameter WDT_CNT_W = 22
) (
	input wire sys_clk,
	input wire reset,
	input wire clk_en,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire timer_ext_clock_pin,
	input wire comparator_out,
	input wire watchdog_enable,
	input wire [5:0] port_direction_eff,
	input wire watchdog_timeout
);
	// ----
	// shadow of option and gap between timeouts
	// ----
	reg [7:0] opt_q;
	reg [15:0] gap_q;
	reg seen_q;
	wire [5:0] ix = paddr[7:2];
	wire bad = |paddr[1:0] | !(ix == 6'h01 | ix == 6'h07 | ix == 6'h08 |
		(ix >= 6'h10 && ix <= 6'h13));
	always @(posedge sys_clk) begin
		if (reset) begin
			opt_q <= 8'hFF;
			gap_q <= 16'h0;
			seen_q <= 1'b0;
		end else begin
			if (psel & penable & pready & pwrite & !pslverr & paddr == 8'h40)
				opt_q <= pwdata[7:0];
			if (watchdog_timeout) begin
				gap_q <= 16'h0;
				seen_q <= 1'b1;
			end else if (gap_q != 16'hFFFF)
				gap_q <= gap_q + 16'h1;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	sequence acc_s;
		psel && penable && !pready;
	endsequence
	apb_wait_a: assert property (acc_s |=> pready)
		else $error("no ready after access");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	bad_addr_a: assert property (acc_s ##0 bad |=> pslverr)
		else $error("bad address not refused");
	good_addr_a: assert property (acc_s ##0 !bad |=> !pslverr)
		else $error("good address refused");
	rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	pin_input_a: assert property (opt_q[5] |-> port_direction_eff[5])
		else $error("clock pin not input");
	wd_gap_a: assert property (watchdog_timeout && seen_q |-> gap_q >= WDT_BASE_CYCLES - 1)
		else $error("timeouts too close");
	wd_pulse_a: assert property (watchdog_timeout |=> !watchdog_timeout)
		else $error("timeout longer than a pulse");
	wd_off_a: assert property (!watchdog_enable [*3] |-> !watchdog_timeout)
		else $error("timeout while disabled");
endmodule // tmz_chk

bind tmz_timer tmz_chk #(.WDT_BASE_CYCLES(WDT_BASE_CYCLES), .WDT_CNT_W(WDT_CNT_W)) chk (
	.sys_clk, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .timer_ext_clock_pin, .comparator_out, .watchdog_enable, .port_direction_eff,
	.watchdog_timeout);

// ---- tmz_src.sv ----
// external count source: clock pin and comparator output
`timescale 1ns/1ps
module tmz_src (
	input wire sys_clk,
	output wire pin,
	output wire cmp
);
	logic [1:0] src_q = 2'b00;
	assign pin = src_q[0];
	assign cmp = src_q[1];
	// n pulses, each level held h clocks, idle low
	task automatic pulse(input int sel, input int n, input int h);
		repeat (n) begin
			repeat (h) @(posedge sys_clk);
			src_q[sel] <= 1'b1;
			repeat (h) @(posedge sys_clk);
			src_q[sel] <= 1'b0;
		end
	endtask
endmodule // tmz_src

// ---- tmz_timer_bench.sv ----
// self-checking bench for the timer zero block
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tmz_timer_bench;
	logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic clk_en = 1'b1;
	logic watchdog_enable = 1'b1, pready, pslverr, err_q, pin, cmp, watchdog_timeout;
	logic [7:0] paddr = 8'h00, a, v;
	logic [31:0] pwdata = 32'h0, prdata, rd_q, lfsr_q = 32'h3B1C;
	logic [5:0] port_direction_eff;
	int fail_count = 0, cmp_count = 0, cyc = 0, wd_n = 0, n, p;
	localparam logic [7:0] A_CNT = 8'h04, A_CMP = 8'h1C, A_OPT = 8'h40;
	localparam logic [7:0] A_DIR = 8'h44, A_OPS = 8'h48;
	localparam logic [7:0] OPTS [5] = '{8'h28, 8'h38, 8'h20, 8'h28, 8'h28};
	localparam logic [7:0] CMPS [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h08, 8'h00};
	initial forever #2.5 sys_clk = ~sys_clk;
	tmz_timer #(.WDT_BASE_CYCLES(16), .WDT_CNT_W(22)) uut (.sys_clk, .reset, .clk_en,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.timer_ext_clock_pin(pin), .comparator_out(cmp), .watchdog_enable,
		.port_direction_eff, .watchdog_timeout);
	tmz_src src (.sys_clk, .pin, .cmp);
	// ----
	// apb master, helpers and closing report
	// ----
	task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		xfer(1'b1, ad, {24'h0, d});
	endtask
	task automatic rd(input logic [7:0] ad);
		xfer(1'b0, ad, 32'h0);
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// watchdog period in clocks; 1:1 while scaler sits on the timer
	function automatic int wd_per(input logic [7:0] o);
		return o[3] ? 16 << o[2:0] : 16;
	endfunction
	// a disabled comparator leaves the pin as source
	function automatic logic [31:0] exp_cnt(input int i, input int k);
		return i == 4 ? 32'h0 : 32'(k);
	endfunction
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// timeout pulses and hang guard
	always @(posedge sys_clk) begin
		cyc++;
		if (watchdog_timeout === 1'b1)
			wd_n++;
		if (cyc == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		rd(A_CNT);
		`CHK("count rst", 32'h0, rd_q)
		rd(A_CMP);
		`CHK("cmp rst", 32'h7F, rd_q)
		`CHK("dir rst", 6'h3F, port_direction_eff)
		rd(8'h0C);
		`CHK("unmapped", 1'b1, err_q)
		rd(8'h05);
		`CHK("unaligned", 1'b1, err_q)
		wr(A_OPT, 8'h08);
		lfsr_q = lfsr_next(lfsr_q);
		v = lfsr_q[7:0];
		wr(A_CNT, v);
		rd(A_CNT);
		`CHK("hold", {24'h0, v}, rd_q)
		wr(A_DIR, 8'h00);
		`CHK("dir int", 6'h00, port_direction_eff)
		wr(A_OPT, 8'h28);
		`CHK("dir ext", 6'h20, port_direction_eff)
		wr(A_OPS, 8'h01);
		// internal clock through every timer ratio
		for (int r = 0; r < 8; r++) begin
			p = 8 << r;
			wr(A_OPT, 8'(r));
			wr(A_CNT, 8'h00);
			repeat (12) @(posedge sys_clk);
			rd(A_CNT);
			a = rd_q[7:0];
			repeat (2 * p - 4) @(posedge sys_clk);
			rd(A_CNT);
			`CHK("ratio", 8'h02, rd_q[7:0] - a)
		end
		repeat (lfsr_q[9:0]) @(posedge sys_clk);
		wr(A_CNT, v);
		repeat (400) @(posedge sys_clk);
		rd(A_CNT);
		`CHK("scaler clear", {24'h0, v}, rd_q)
		// pin, falling edge, divided pin, comparator, comparator off
		for (int i = 0; i < 5; i++) begin
			wr(A_CMP, CMPS[i]);
			wr(A_OPT, OPTS[i]);
			wr(A_CNT, 8'h00);
			repeat (12) @(posedge sys_clk);
			lfsr_q = lfsr_next(lfsr_q);
			n = 1 + lfsr_q[3:0];
			src.pulse(i > 2, n * (i == 2 ? 2 : 1), 4);
			repeat (20) @(posedge sys_clk);
			rd(A_CNT);
			`CHK("ext count", exp_cnt(i, n), rd_q)
		end
		// watchdog periods for ratios 1:1 to 1:8, then with scaler on timer
		for (int i = 0; i < 5; i++) begin
			v = i < 4 ? 8'h08 | 8'(i) : 8'h07;
			p = wd_per(v);
			wr(A_OPT, v);
			wr(A_OPS, 8'h01);
			@(negedge sys_clk);
			wd_n = 0;
			repeat (4 * p + p / 2) @(negedge sys_clk);
			`CHK("wd periods", 4, wd_n)
			@(posedge sys_clk);
		end
		// move scaler to watchdog, then keep clearing it
		wr(A_OPS, 8'h01);
		wr(A_CNT, 8'h00);
		wr(A_OPT, 8'h0B);
		@(negedge sys_clk);
		wd_n = 0;
		for (int k = 0; k < 6; k++) begin
			repeat (60) @(posedge sys_clk);
			wr(A_OPS, k[0] ? 8'h02 : 8'h01);
		end
		@(negedge sys_clk);
		`CHK("wd cleared", 0, wd_n)
		@(posedge sys_clk);
		watchdog_enable <= 1'b0;
		@(negedge sys_clk);
		wd_n = 0;
		repeat (300) @(negedge sys_clk);
		`CHK("wd off", 0, wd_n)
		// freeze right after a count write: the hold must stay frozen through the pause
		@(posedge sys_clk);
		lfsr_q = lfsr_next(lfsr_q);
		v = lfsr_q[7:0];
		wr(A_CNT, v);
		clk_en <= 1'b0;
		repeat (100) @(posedge sys_clk);
		clk_en <= 1'b1;
		rd(A_CNT);
		`CHK("freeze", {24'h0, v}, rd_q)
		wrap_up();
	end
endmodule // tmz_timer_bench
